//--- hdl/gpfc_map.svh
`ifndef GPFC_MAP_SVH
`define GPFC_MAP_SVH
// Report identifiers
`define GPFC_ID_GPIO_CFG 8'h49
`define GPFC_ID_SUSP_CFG 8'h4a
// Byte offsets inside the GPIO configuration report
`define GPFC_OFS_DIR_HI 4'h1
`define GPFC_OFS_DIR_LO 4'h2
`define GPFC_OFS_OD_HI 4'h3
`define GPFC_OFS_OD_LO 4'h4
`define GPFC_OFS_PU_HI 4'h5
`define GPFC_OFS_PU_LO 4'h6
`define GPFC_OFS_PD_HI 4'h7
`define GPFC_OFS_PD_LO 4'h8
`define GPFC_OFS_CLK_HI 4'h9
`define GPFC_OFS_CLK_LO 4'ha
`define GPFC_OFS_MODE0 4'hb
`define GPFC_OFS_MODE1 4'hc
// Byte offsets inside the suspend report
`define GPFC_OFS_SLVL_HI 4'h1
`define GPFC_OFS_SLVL_LO 4'h2
`define GPFC_OFS_SDRV_HI 4'h3
`define GPFC_OFS_SDRV_LO 4'h4
// Writable bits of a mask: pin bits, plus the suspend use flag at bit 15 in the suspend mask
`define GPFC_PIN_MASK 16'h3ccf
`define GPFC_SUSP_MASK 16'hbccf
`define GPFC_USE_SUSP_BIT 15
// Mode bytes
`define GPFC_MODE0_MASK 8'h7f
`define GPFC_MODE1_MASK 8'hc1
`define GPFC_MODE0_RESET 8'h01
`define GPFC_BIT_CLK_EN 0
`define GPFC_BIT_TRANSMIT_TOGGLE_ENABLE 6
`define GPFC_BIT_RECEIVE_TOGGLE_ENABLE 7
`define GPFC_BIT_HD_POL 3
`define GPFC_BIT_HD_PIN 4
// Pin numbers
`define GPFC_PIN_CLK 0
`define GPFC_PIN_RTS 1
`define GPFC_PIN_CTS 2
`define GPFC_PIN_HD 3
`define GPFC_PIN_TXT 4
`define GPFC_PIN_RXT 5
`define GPFC_PIN_DTR 8
`define GPFC_PIN_DSR 9
// Reference clock: 24 MHz from 100 MHz core by fractional accumulator
`define GPFC_REF_NUM 8'h18
`define GPFC_REF_DEN 8'h64
`endif

//--- hdl/gpfc_pkg.sv
package gpfc_pkg;
	typedef enum logic [1:0] {
		GPFC_G3_GPIO = 2'b00,
		GPFC_G3_HD_AUTO = 2'b01,
		GPFC_G3_HD_ADDR = 2'b10,
		GPFC_G3_RSVD = 2'b11
	} gpfc_g3_fn_type;
	typedef enum logic [2:0] {
		GPFC_MS_NONE = 3'b000,
		GPFC_MS_RTSCTS = 3'b001,
		GPFC_MS_DTRDSR = 3'b010,
		GPFC_MS_TX = 3'b011,
		GPFC_MS_TX_ADDR = 3'b100
	} gpfc_modem_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] report_id;
		logic [3:0] offset;
		logic [7:0] wdata;
	} gpfc_req_type;
	typedef struct packed {
		logic [9:0] out;
		logic [9:0] oe;
		logic [9:0] pull_up;
		logic [9:0] pull_down;
	} gpfc_pins_type;
	typedef struct packed {
		logic tx_active;
		logic tx_addr_match;
		logic rts_n;
		logic dtr_n;
		logic tx_toggle;
		logic rx_toggle;
	} gpfc_uart_type;
endpackage

//--- hdl/gpfc_clk_div.sv
`timescale 1ns/100ps
`include "gpfc_map.svh"
module gpfc_clk_div (
	input wire logic clock_i, // Core clock
	input wire logic reset_i, // Synchronous reset
	input wire logic [7:0] high_i, // High period in reference cycles
	input wire logic [7:0] low_i, // Low period in reference cycles
	output logic ref_en_o, // 24 MHz reference enable
	output logic clk_o // Divided clock level
);
	logic [7:0] acc_q;
	logic [8:0] cnt_q;
	logic [8:0] acc_sum;
	logic ref_tick;
	logic in_high;
	logic [8:0] period;
	logic [8:0] hi_ext;

	assign acc_sum = {1'b0, acc_q} + {1'b0, `GPFC_REF_NUM};
	assign ref_tick = (acc_sum >= {1'b0, `GPFC_REF_DEN});
	assign period = {1'b0, high_i} + {1'b0, low_i};
	assign hi_ext = {1'b0, high_i};
	assign in_high = (cnt_q < hi_ext);

	// Fractional accumulator keeps the average rate exact at 24/100
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			acc_q <= 8'h00;
		end else if (ref_tick) begin
			acc_q <= 8'(acc_sum - {1'b0, `GPFC_REF_DEN});
		end else begin
			acc_q <= acc_sum[7:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cnt_q <= 9'h000;
		end else if (ref_tick) begin
			if (period == 9'h000 || cnt_q + 9'h001 >= period) begin // R02
				cnt_q <= 9'h000;
			end else begin
				cnt_q <= cnt_q + 9'h001;
			end
		end
	end

	// Undivided reference is the tick itself: a one-cycle pulse keeps the full 24 MHz rate at a poor duty
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			clk_o <= 1'b0;
			ref_en_o <= 1'b0;
		end else begin
			ref_en_o <= ref_tick;
			if (period == 9'h000) begin
				clk_o <= ref_tick; // R03
			end else begin
				clk_o <= in_high; // R23
			end
		end
	end
endmodule

//--- hdl/gpfc_top.sv
`timescale 1ns/100ps
`include "gpfc_map.svh"
// Operation
// R01: Mask bits 13:10, 7:6, 3:0 map GPIO9..6, 5..4, 3..0; others reserved.
// R02: Clock output is 24 MHz divided by high plus low periods.
// R03: Both divider values zero gives the undivided 24 MHz reference.
// R04: Divided clock reaches GPIO0 only when clock function selected.
// R05: Mode byte 1 bit 0 enables clock output, else GPIO.
// R06: Mode byte 1 bit 7 enables receive toggle on GPIO5.
// R07: Mode byte 1 bit 6 enables transmit toggle on GPIO4.
// R08: Mode byte 0 bits 6:5 pick GPIO3 function; 11 reserved.
// R09: Mode byte 0 bit 4 picks GPIO1 or GPIO3 for half-duplex enable.
// R10: Mode byte 0 bit 3 sets half-duplex enable polarity, 1 high.
// R11: Modem-select 000 none, 001 RTS/CTS default, 010 DTR/DSR.
// R12: Modem-select 011 assert GPIO1 on transmit, 100 only after address match.
// R13: Host must enable UART hardware flow control when choosing RTS/CTS.
// R14: In suspend with use flag, pins drive their suspend level.
// R15: In suspend with use flag, suspend-mode bit 0 open drain, 1 push-pull.
// R16: Suspend level and drive words reset to zero.
// R17: Suspend report 0x4A carries level bytes 1,2 and drive bytes 3,4.
// R18: Direction bit 0 input, 1 output.
// R19: Open-drain bit 0 open drain, 1 push-pull.
// R20: Pull-up wins over pull-down when both set on input.
// R21: Special-function pins ignore direction, open-drain and pull masks.
// R22: Reserved bits ignored on write and read as zero.
// R23: Divided clock high for high count, low for low count, repeating.
module gpfc_top #(
	parameter int PINS = 10
) (
	input wire logic clock_i, // Core clock, 100 MHz
	input wire logic reset_i, // Synchronous reset, active high
	input wire gpfc_pkg::gpfc_req_type req_i, // Report byte access
	output logic [7:0] rdata_o, // Read data, valid cycle after rd
	input wire logic [PINS-1:0] gpio_i, // Pin levels
	input wire logic [PINS-1:0] gpio_out_i, // GPIO output values from data register
	input wire logic usb_suspend_i, // USB suspended
	input wire gpfc_pkg::gpfc_uart_type uart_i, // UART side signals
	output gpfc_pkg::gpfc_pins_type pins_o, // Pin drive controls
	output logic [PINS-1:0] gpio_in_o, // Registered pin levels
	output logic cts_n_o, // CTS from GPIO2
	output logic dsr_n_o, // DSR from GPIO9
	output logic flow_rtscts_o, // RTS/CTS pins in use
	output logic flow_dtrdsr_o // DTR/DSR pins in use
);
	logic [15:0] dir_q;
	logic [15:0] od_q;
	logic [15:0] pu_q;
	logic [15:0] pd_q;
	logic [15:0] slvl_q;
	logic [15:0] sdrv_q;
	logic [7:0] clk_hi_q;
	logic [7:0] clk_lo_q;
	logic [7:0] mode0_q;
	logic [7:0] mode1_q;
	logic [7:0] rdata_d;
	logic div_clk;
	logic wr_cfg;
	logic wr_susp;
	logic [PINS-1:0] special;
	logic [PINS-1:0] spec_val;
	logic [PINS-1:0] spec_oe;
	logic [PINS-1:0] dir_p;
	logic [PINS-1:0] od_p;
	logic [PINS-1:0] pu_p;
	logic [PINS-1:0] pd_p;
	logic [PINS-1:0] lvl_p;
	logic [PINS-1:0] drv_p;
	logic hd_level;
	logic hd_active;
	logic suspended;
	gpfc_pkg::gpfc_g3_fn_type g3_fn;
	gpfc_pkg::gpfc_modem_type modem;
	gpfc_pkg::gpfc_pins_type pins_d;
	localparam logic [15:0] PIN_MASK = `GPFC_PIN_MASK;
	localparam logic [15:0] SUSP_MASK = `GPFC_SUSP_MASK;

	assign wr_cfg = req_i.wr && req_i.report_id == `GPFC_ID_GPIO_CFG;
	assign wr_susp = req_i.wr && req_i.report_id == `GPFC_ID_SUSP_CFG;

	// Reserved bits are masked off at write so they always read as zero
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			dir_q <= 16'h0000;
			od_q <= 16'h0000;
			pu_q <= 16'h0000;
			pd_q <= 16'h0000;
		end else if (wr_cfg) begin
			case (req_i.offset)
				`GPFC_OFS_DIR_HI: dir_q[15:8] <= req_i.wdata & PIN_MASK[15:8]; // R22
				`GPFC_OFS_DIR_LO: dir_q[7:0] <= req_i.wdata & PIN_MASK[7:0]; // R22
				`GPFC_OFS_OD_HI: od_q[15:8] <= req_i.wdata & PIN_MASK[15:8];
				`GPFC_OFS_OD_LO: od_q[7:0] <= req_i.wdata & PIN_MASK[7:0];
				`GPFC_OFS_PU_HI: pu_q[15:8] <= req_i.wdata & PIN_MASK[15:8];
				`GPFC_OFS_PU_LO: pu_q[7:0] <= req_i.wdata & PIN_MASK[7:0];
				`GPFC_OFS_PD_HI: pd_q[15:8] <= req_i.wdata & PIN_MASK[15:8];
				`GPFC_OFS_PD_LO: pd_q[7:0] <= req_i.wdata & PIN_MASK[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			clk_hi_q <= 8'h00;
			clk_lo_q <= 8'h00;
			mode0_q <= `GPFC_MODE0_RESET; // R11
			mode1_q <= 8'h00;
		end else if (wr_cfg) begin
			case (req_i.offset)
				`GPFC_OFS_CLK_HI: clk_hi_q <= req_i.wdata;
				`GPFC_OFS_CLK_LO: clk_lo_q <= req_i.wdata;
				`GPFC_OFS_MODE0: mode0_q <= req_i.wdata & `GPFC_MODE0_MASK; // R22
				`GPFC_OFS_MODE1: mode1_q <= req_i.wdata & `GPFC_MODE1_MASK; // R22
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			slvl_q <= 16'h0000; // R16
			sdrv_q <= 16'h0000; // R16
		end else if (wr_susp) begin
			case (req_i.offset)
				`GPFC_OFS_SLVL_HI: slvl_q[15:8] <= req_i.wdata & SUSP_MASK[15:8]; // R17
				`GPFC_OFS_SLVL_LO: slvl_q[7:0] <= req_i.wdata & SUSP_MASK[7:0]; // R17
				`GPFC_OFS_SDRV_HI: sdrv_q[15:8] <= req_i.wdata & SUSP_MASK[15:8]; // R17
				`GPFC_OFS_SDRV_LO: sdrv_q[7:0] <= req_i.wdata & SUSP_MASK[7:0]; // R17
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		if (req_i.report_id == `GPFC_ID_GPIO_CFG) begin
			case (req_i.offset)
				`GPFC_OFS_DIR_HI: rdata_d = dir_q[15:8];
				`GPFC_OFS_DIR_LO: rdata_d = dir_q[7:0];
				`GPFC_OFS_OD_HI: rdata_d = od_q[15:8];
				`GPFC_OFS_OD_LO: rdata_d = od_q[7:0];
				`GPFC_OFS_PU_HI: rdata_d = pu_q[15:8];
				`GPFC_OFS_PU_LO: rdata_d = pu_q[7:0];
				`GPFC_OFS_PD_HI: rdata_d = pd_q[15:8];
				`GPFC_OFS_PD_LO: rdata_d = pd_q[7:0];
				`GPFC_OFS_CLK_HI: rdata_d = clk_hi_q;
				`GPFC_OFS_CLK_LO: rdata_d = clk_lo_q;
				`GPFC_OFS_MODE0: rdata_d = mode0_q;
				`GPFC_OFS_MODE1: rdata_d = mode1_q;
				default: rdata_d = 8'h00;
			endcase
		end else if (req_i.report_id == `GPFC_ID_SUSP_CFG) begin
			case (req_i.offset)
				`GPFC_OFS_SLVL_HI: rdata_d = slvl_q[15:8];
				`GPFC_OFS_SLVL_LO: rdata_d = slvl_q[7:0];
				`GPFC_OFS_SDRV_HI: rdata_d = sdrv_q[15:8];
				`GPFC_OFS_SDRV_LO: rdata_d = sdrv_q[7:0];
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (req_i.rd) begin
			rdata_o <= rdata_d;
		end
	end

	gpfc_clk_div u_div (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.high_i(clk_hi_q),
		.low_i(clk_lo_q),
		.ref_en_o(),
		.clk_o(div_clk)
	);

	// Pin-number view of the 16-bit masks
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_map
			localparam int B = (gi < 4) ? gi : ((gi < 6) ? gi + 2 : gi + 4); // R01
			assign dir_p[gi] = dir_q[B];
			assign od_p[gi] = od_q[B];
			assign pu_p[gi] = pu_q[B];
			assign pd_p[gi] = pd_q[B];
			assign lvl_p[gi] = slvl_q[B];
			assign drv_p[gi] = sdrv_q[B];
		end
	endgenerate

	assign g3_fn = gpfc_pkg::gpfc_g3_fn_type'(mode0_q[6:5]);
	assign modem = gpfc_pkg::gpfc_modem_type'(mode0_q[2:0]);
	assign suspended = usb_suspend_i && slvl_q[`GPFC_USE_SUSP_BIT];

	// Half-duplex activity per the chosen pin's own function field
	always_comb begin
		hd_active = 1'b0;
		if (mode0_q[`GPFC_BIT_HD_PIN]) begin // R09
			case (g3_fn)
				gpfc_pkg::GPFC_G3_HD_AUTO: hd_active = uart_i.tx_active; // R08
				gpfc_pkg::GPFC_G3_HD_ADDR: hd_active = uart_i.tx_active && uart_i.tx_addr_match; // R08
				default: hd_active = 1'b0;
			endcase
		end else begin
			case (modem)
				gpfc_pkg::GPFC_MS_TX: hd_active = uart_i.tx_active; // R12
				gpfc_pkg::GPFC_MS_TX_ADDR: hd_active = uart_i.tx_active && uart_i.tx_addr_match; // R12
				default: hd_active = 1'b0;
			endcase
		end
	end
	assign hd_level = mode0_q[`GPFC_BIT_HD_POL] ? hd_active : ~hd_active; // R10

	always_comb begin
		special = '0;
		spec_val = '0;
		spec_oe = '0;
		if (mode1_q[`GPFC_BIT_CLK_EN]) begin // R05
			special[`GPFC_PIN_CLK] = 1'b1; // R04
			spec_val[`GPFC_PIN_CLK] = div_clk;
			spec_oe[`GPFC_PIN_CLK] = 1'b1;
		end
		if (mode1_q[`GPFC_BIT_TRANSMIT_TOGGLE_ENABLE]) begin // R07
			special[`GPFC_PIN_TXT] = 1'b1;
			spec_val[`GPFC_PIN_TXT] = uart_i.tx_toggle;
			spec_oe[`GPFC_PIN_TXT] = 1'b1;
		end
		if (mode1_q[`GPFC_BIT_RECEIVE_TOGGLE_ENABLE]) begin // R06
			special[`GPFC_PIN_RXT] = 1'b1;
			spec_val[`GPFC_PIN_RXT] = uart_i.rx_toggle;
			spec_oe[`GPFC_PIN_RXT] = 1'b1;
		end
		case (modem) // R11
			gpfc_pkg::GPFC_MS_RTSCTS: begin
				special[`GPFC_PIN_RTS] = 1'b1;
				spec_val[`GPFC_PIN_RTS] = uart_i.rts_n;
				spec_oe[`GPFC_PIN_RTS] = 1'b1;
				special[`GPFC_PIN_CTS] = 1'b1;
			end
			gpfc_pkg::GPFC_MS_DTRDSR: begin
				special[`GPFC_PIN_DTR] = 1'b1;
				spec_val[`GPFC_PIN_DTR] = uart_i.dtr_n;
				spec_oe[`GPFC_PIN_DTR] = 1'b1;
				special[`GPFC_PIN_DSR] = 1'b1;
			end
			gpfc_pkg::GPFC_MS_TX, gpfc_pkg::GPFC_MS_TX_ADDR: begin
				if (!mode0_q[`GPFC_BIT_HD_PIN]) begin
					special[`GPFC_PIN_RTS] = 1'b1;
					spec_val[`GPFC_PIN_RTS] = hd_level;
					spec_oe[`GPFC_PIN_RTS] = 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (mode0_q[`GPFC_BIT_HD_PIN] &&
			(g3_fn == gpfc_pkg::GPFC_G3_HD_AUTO || g3_fn == gpfc_pkg::GPFC_G3_HD_ADDR)) begin
			special[`GPFC_PIN_HD] = 1'b1;
			spec_val[`GPFC_PIN_HD] = hd_level;
			spec_oe[`GPFC_PIN_HD] = 1'b1;
		end
	end

	// Open drain drives only a low, otherwise floats
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			pins_d.out[i] = 1'b0;
			pins_d.oe[i] = 1'b0;
			pins_d.pull_up[i] = 1'b0;
			pins_d.pull_down[i] = 1'b0;
			if (suspended) begin
				pins_d.out[i] = lvl_p[i]; // R14
				pins_d.oe[i] = drv_p[i] | ~lvl_p[i]; // R15
			end else if (special[i]) begin
				pins_d.out[i] = spec_val[i]; // R21
				pins_d.oe[i] = spec_oe[i];
			end else if (dir_p[i]) begin // R18
				pins_d.out[i] = od_p[i] ? gpio_out_i[i] : 1'b0; // R19
				pins_d.oe[i] = od_p[i] | ~gpio_out_i[i]; // R19
			end else begin
				pins_d.pull_up[i] = pu_p[i]; // R20
				pins_d.pull_down[i] = pd_p[i] & ~pu_p[i]; // R20
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pins_o <= '0;
			gpio_in_o <= '0;
			cts_n_o <= 1'b1;
			dsr_n_o <= 1'b1;
			flow_rtscts_o <= 1'b0;
			flow_dtrdsr_o <= 1'b0;
		end else begin
			pins_o <= pins_d;
			gpio_in_o <= gpio_i;
			cts_n_o <= (modem == gpfc_pkg::GPFC_MS_RTSCTS) ? gpio_i[`GPFC_PIN_CTS] : 1'b0;
			dsr_n_o <= (modem == gpfc_pkg::GPFC_MS_DTRDSR) ? gpio_i[`GPFC_PIN_DSR] : 1'b0;
			flow_rtscts_o <= (modem == gpfc_pkg::GPFC_MS_RTSCTS); // R13
			flow_dtrdsr_o <= (modem == gpfc_pkg::GPFC_MS_DTRDSR);
		end
	end

	a_reserved_zero: assert property (@(posedge clock_i) disable iff (reset_i) // R22
		(dir_q & ~`GPFC_PIN_MASK) == 16'h0000 && (mode1_q & ~`GPFC_MODE1_MASK) == 8'h00)
		else $error("reserved bits set");
	a_suspend_level: assert property (@(posedge clock_i) disable iff (reset_i) // R14
		suspended && !$rose(suspended) |=> pins_o.out == $past(lvl_p))
		else $error("suspend level wrong");
	a_pullup_wins: assert property (@(posedge clock_i) disable iff (reset_i) // R20
		(pins_o.pull_up & pins_o.pull_down) == '0)
		else $error("pull up and down both on");
	a_clock_gate: assert property (@(posedge clock_i) disable iff (reset_i) // R05
		!suspended && !mode1_q[`GPFC_BIT_CLK_EN] && !dir_p[`GPFC_PIN_CLK] |=> !pins_o.oe[`GPFC_PIN_CLK])
		else $error("clock pin driven while disabled");
	a_hd_polarity: assert property (@(posedge clock_i) disable iff (reset_i) // R10
		!suspended && mode0_q[`GPFC_BIT_HD_PIN] && g3_fn == gpfc_pkg::GPFC_G3_HD_AUTO
		|=> pins_o.out[`GPFC_PIN_HD] == ($past(uart_i.tx_active) ~^ $past(mode0_q[`GPFC_BIT_HD_POL])))
		else $error("half duplex level wrong");
	a_susp_reset: assert property (@(posedge clock_i) $fell(reset_i) |-> slvl_q == 16'h0000 && sdrv_q == 16'h0000) // R16
		else $error("suspend words not reset");
	a_txt_route: assert property (@(posedge clock_i) disable iff (reset_i) // R07
		!suspended && mode1_q[`GPFC_BIT_TRANSMIT_TOGGLE_ENABLE] |=> pins_o.out[`GPFC_PIN_TXT] == $past(uart_i.tx_toggle))
		else $error("transmit toggle not routed");
	a_rxt_route: assert property (@(posedge clock_i) disable iff (reset_i) // R06
		!suspended && mode1_q[`GPFC_BIT_RECEIVE_TOGGLE_ENABLE] |=> pins_o.out[`GPFC_PIN_RXT] == $past(uart_i.rx_toggle))
		else $error("receive toggle not routed");
endmodule

//--- verification/gpfc_pin_model.sv
`timescale 1ns/100ps
module gpfc_pin_model (
	input wire logic clock_i, // Core clock
	input wire gpfc_pkg::gpfc_pins_type pins_i, // Drive controls from the block
	input wire logic [9:0] ext_en_i, // Far side drives the pin
	input wire logic [9:0] ext_lvl_i, // Level the far side drives
	output logic [9:0] level_o // Resolved pin level
);
	logic [9:0] last_q = '0;
	always_ff @(posedge clock_i) begin
		last_q <= level_o;
	end
	// A floating pin flips every cycle so that no stale level can pass for a real one
	always_comb begin
		for (int k = 0; k < 10; k++) begin
			if (pins_i.oe[k]) level_o[k] = pins_i.out[k];
			else if (ext_en_i[k]) level_o[k] = ext_lvl_i[k];
			else if (pins_i.pull_up[k]) level_o[k] = 1'b1;
			else if (pins_i.pull_down[k]) level_o[k] = 1'b0;
			else level_o[k] = ~last_q[k];
		end
	end
endmodule

//--- verification/gpio_pin_function_control_bench.sv
`timescale 1ns/100ps
module gpio_pin_function_control_bench;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	gpfc_pkg::gpfc_req_type req = '0;
	gpfc_pkg::gpfc_uart_type uart = '0;
	gpfc_pkg::gpfc_pins_type pins;
	logic [9:0] gpio_i, gin, gout = '0, ext_lvl = '0, ext_en = '0;
	logic susp = 1'b0, rd_d = 1'b0, pc = 1'b0, meas = 1'b0, last0 = 1'b0;
	logic cts_n, dsr_n, f_rc, f_dd;
	logic [7:0] rdata, sh[2][16];
	logic [53:0] pv, pm;
	logic [107:0] pq[$];
	logic [7:0] rq[$];
	logic [15:0] fn[12] = '{16'h01c0, 16'h0200, 16'h0300, 16'h0b00, 16'h0400, 16'h0c00,
		16'h3000, 16'h3800, 16'h5800, 16'h7800, 16'h0500, 16'h0101};
	logic [15:0] ck[4] = '{16'h0101, 16'h0201, 16'h0000, 16'h0305};
	int n_mismatch = 0, tests_run = 0, cyc = 0, edges = 0, highs = 0;
	always #5 clock_i = ~clock_i;
	gpfc_top dut_u (.clock_i(clock_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata), .gpio_i(gpio_i),
		.gpio_out_i(gout), .usb_suspend_i(susp), .uart_i(uart), .pins_o(pins), .gpio_in_o(gin),
		.cts_n_o(cts_n), .dsr_n_o(dsr_n), .flow_rtscts_o(f_rc), .flow_dtrdsr_o(f_dd));
	gpfc_pin_model pin_u (.clock_i(clock_i), .pins_i(pins), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl),
		.level_o(gpio_i));
	task final_report;
		$display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task cmp_rd(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: read %h expected %h", $time, g, e);
		end
	endtask
	task cmp_pins(input logic [53:0] g, input logic [53:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: pins %h expected %h", $time, g, e);
		end
	endtask
	task cmp_near(input int g, input int e, input int tol);
		tests_run++;
		if (g > e + tol || g < e - tol) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: count %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [7:0] fmask(input int r, input int o);
		if (o < 1 || o > 12 || (r == 1 && o > 4)) return 8'h00;
		if (r == 1) return o[0] ? 8'hbc : 8'hcf;
		if (o < 9) return o[0] ? 8'h3c : 8'hcf;
		return o == 11 ? 8'h7f : (o == 12 ? 8'hc1 : 8'hff);
	endfunction
	task wr(input int r, input int o, input logic [7:0] v);
		@(posedge clock_i);
		req <= '{1'b1, 1'b0, 8'h49 + 8'(r), 4'(o), v};
		if (r < 2) sh[r][o] = v & fmask(r, o);
		@(posedge clock_i);
		req <= '0;
	endtask
	task rd(input int r, input int o);
		@(posedge clock_i);
		req <= '{1'b0, 1'b1, 8'h49 + 8'(r), 4'(o), 8'h00};
		rq.push_back(r < 2 ? sh[r][o] : 8'h00);
		@(posedge clock_i);
		req <= '0;
	endtask
	task rnd_io;
		gout <= 10'($urandom());
		ext_lvl <= 10'($urandom());
		uart <= gpfc_pkg::gpfc_uart_type'(6'($urandom()));
	endtask
	task calc;
		logic [7:0] m0, m1;
		logic [15:0] dir, od, pu, pd, lv, dv;
		logic sp, a, t, o, e, u, d;
		int b;
		m0 = sh[0][11];
		m1 = sh[0][12];
		dir = {sh[0][1], sh[0][2]};
		od = {sh[0][3], sh[0][4]};
		pu = {sh[0][5], sh[0][6]};
		pd = {sh[0][7], sh[0][8]};
		lv = {sh[1][1], sh[1][2]};
		dv = {sh[1][3], sh[1][4]};
		sp = susp & lv[15];
		t = uart.tx_active & (~(m0[4] ? m0[6] : m0[2]) | uart.tx_addr_match);
		pm = '1;
		pm[3:2] = {ext_en[2], ext_en[9]};
		pv = {50'h0, m0[2:0] == 3'd1 && ext_lvl[2], m0[2:0] == 3'd2 && ext_lvl[9], m0[2:0] == 3'd1, m0[2:0] == 3'd2};
		for (int k = 0; k < 10; k++) begin
			b = k < 4 ? k : (k < 6 ? k + 2 : k + 4);
			a = m0[4] ? (k == 3 && m0[6] != m0[5]) : (k == 1 && m0[2:0] inside {3'd3, 3'd4});
			{o, e, u, d} = 4'h0;
			if (sp) {o, e} = {lv[b], dv[b] | ~lv[b]};
			else if (a) {o, e} = {m0[3] ~^ t, 1'b1};
			else if (k == 0 && m1[0]) {pm[34], e} = 2'b01;
			else if (k == 4 && m1[6]) {o, e} = {uart.tx_toggle, 1'b1};
			else if (k == 5 && m1[7]) {o, e} = {uart.rx_toggle, 1'b1};
			else if ((k == 1 && m0[2:0] == 3'd1) || (k == 8 && m0[2:0] == 3'd2)) {o, e} = {k == 1 ? uart.rts_n : uart.dtr_n, 1'b1};
			else if ((k == 2 && m0[2:0] == 3'd1) || (k == 9 && m0[2:0] == 3'd2)) {pm[34+k], pm[14+k], pm[4+k]} = 3'b000;
			else if (dir[b]) {o, e} = {od[b] & gout[k], od[b] | ~gout[k]};
			else {u, d} = {pu[b], pd[b] & ~pu[b]};
			{pv[34+k], pv[24+k], pv[14+k], pv[4+k]} = {o, e, u, d};
			// Input path sees our drive first, then the far side, then a pull; a bare float is not predictable
			pv[44+k] = e ? o : (ext_en[k] ? ext_lvl[k] : u);
			pm[44+k] = e ? pm[34+k] : (ext_en[k] | u | d);
		end
	endtask
	// Pin outputs need two cycles after a write, so four leave margin for the input path
	task chk;
		repeat (4) @(posedge clock_i);
		calc();
		pq.push_back({pm, pv});
		pc <= 1'b1;
		@(posedge clock_i);
		pc <= 1'b0;
	endtask
	always @(posedge clock_i) begin
		rd_d <= req.rd;
		if (rd_d && rq.size() > 0) cmp_rd(rdata, rq.pop_front());
		if (pc && pq.size() > 0) begin
			cmp_pins({gin, pins, cts_n, dsr_n, f_rc, f_dd} & pq[0][107:54], pq[0][53:0] & pq[0][107:54]);
			void'(pq.pop_front());
		end
		if (meas && pins.out[0] === 1'b1 && last0 === 1'b0) edges <= edges + 1;
		if (meas && pins.out[0] === 1'b1) highs <= highs + 1;
		last0 <= pins.out[0];
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		int h, l, n;
		foreach (sh[i, j]) sh[i][j] = 8'h00;
		sh[0][11] = 8'h01;
		void'($urandom(32'h30083064));
		repeat (20) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			for (int r = 0; r < 3; r++) for (int o = 0; o < 14; o++) rd(r, o);
			if (p == 0) chk();
			for (int r = 0; r < 3; r++) for (int o = 1; o < 14; o++) wr(r, o, 8'($urandom()));
		end
		wr(0, 11, 8'h00);
		wr(0, 12, 8'h00);
		wr(1, 1, 8'h00);
		repeat (6) begin
			for (int o = 1; o < 9; o++) wr(0, o, 8'($urandom()));
			rnd_io();
			chk();
		end
		ext_en <= '1;
		foreach (fn[i]) begin
			wr(0, 11, fn[i][15:8]);
			wr(0, 12, fn[i][7:0]);
			repeat (3) begin
				rnd_io();
				chk();
			end
		end
		// Fractional reference jitters by a core cycle, hence the tolerances
		foreach (ck[i]) begin
			h = ck[i][15:8];
			l = ck[i][7:0];
			wr(0, 9, ck[i][15:8]);
			wr(0, 10, ck[i][7:0]);
			n = (h + l == 0) ? 1 : h + l;
			repeat (50) @(posedge clock_i);
			edges = 0;
			highs = 0;
			meas <= 1'b1;
			repeat (1000) @(posedge clock_i);
			meas <= 1'b0;
			@(posedge clock_i);
			cmp_near(edges, 240 / n, 2);
			cmp_near(highs, (h + l == 0 ? 240 : 1000 * h) / n, 40);
		end
		wr(0, 11, 8'h00);
		wr(0, 12, 8'h00);
		for (int s = 0; s < 4; s++) begin
			susp <= s[0];
			wr(1, 1, {s[1], 7'($urandom())});
			for (int o = 2; o < 5; o++) wr(1, o, 8'($urandom()));
			rnd_io();
			chk();
		end
		// Let the checker take the last queued note before the verdict
		repeat (2) @(posedge clock_i);
		final_report();
	end
endmodule
